// file: verilog/pic_top.sv
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1: Up to 128 internal and external source lines are accepted, enabled and ranked.
// R2: Each source is enabled by whole enable words or by writing its number to enable or disable registers.
// R3: An enabled, asserted source raises the normal or the fast request as its type bit selects.
// R4: Register accesses outside supervisor mode take no effect, and the core must make them in supervisor mode.
// R5: Fast requests rank first; among normal ones the highest level wins, then the highest number.
// R6: Each source has one of sixteen levels, level zero being the lowest.
// R7: Levels sit in eight writable level registers, each packing the fields of a group of sources.
// R8: A writable normal mask register suppresses normal requests by level.
// R9: A normal request is signalled only when its level is strictly above the mask.
// R10: Sources are level sensitive and a request drops once no qualifying source remains.
module pic_top (
    // Clock and reset
    input  wire logic                          i_core_clk,
    input  wire logic                          i_sys_rst,
    // Interrupt source lines
    input  wire logic [pic_pkg::NSRC-1:0]      i_src,
    // Register port
    input  wire logic [pic_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [pic_pkg::DATA_W-1:0]    i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    input  wire logic                          i_supervisor,
    output logic      [pic_pkg::DATA_W-1:0]    o_rdata,
    // Requests toward the core
    output logic                               o_nirq,
    output logic                               o_firq,
    output logic      [pic_pkg::VEC_W-1:0]     o_vector,
    // Controller event interrupt
    output logic                               o_irq
);
    localparam int NS = pic_pkg::NSRC;
    localparam int DW = pic_pkg::DATA_W;
    localparam int PW = pic_pkg::NSRC * pic_pkg::LVL_W;

    // =====================================================
    // State
    logic [NS-1:0]               s1_r, s2_r;
    logic [NS-1:0]               enable_r, enable_nxt;
    logic [NS-1:0]               type_r, type_nxt;
    logic [pic_pkg::LVL_W-1:0]   mask_r, mask_nxt;
    logic [PW-1:0]               prio_r, prio_nxt;
    logic [pic_pkg::NEV-1:0]     istat_r, istat_nxt;
    logic [pic_pkg::NEV-1:0]     ien_r, ien_nxt;
    logic [DW-1:0]               rdata_r, rdata_nxt;
    logic                        nirq_r, nirq_nxt;
    logic                        firq_r, firq_nxt;
    logic [pic_pkg::VEC_W-1:0]   vec_r, vec_nxt;
    logic                        irq_r, irq_nxt;

    // Derived request terms
    logic [NS-1:0]               pend, fast_req, norm_req;
    logic                        fast_any, nsig;
    logic [pic_pkg::SRC_W-1:0]   fast_idx;
    logic                        wr_ok, rd_ok, priv_bad, prio_hit;
    logic [pic_pkg::NEV-1:0]     ev, clr;

    pic_prio_if rk ();

    prio_rank u_rank (
        .p (rk)
    );

    // Highest set bit of a request vector
    function automatic logic [pic_pkg::SRC_W-1:0] top_bit(logic [NS-1:0] v);
        top_bit = '0;
        for (int i = 0; i < NS; i++) begin
            if (v[i]) begin
                top_bit = 7'(i);
            end
        end
    endfunction

    // =====================================================
    // Source synchroniser, two stages before any use
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= i_src; // R1
            s2_r <= s1_r;
        end
    end

    // =====================================================
    // Request split and ranking
    always_comb begin
        pend     = s2_r & enable_r;        // R3 R10
        fast_req = pend & type_r;          // R3
        norm_req = pend & ~type_r;
        fast_any = |fast_req;
        fast_idx = top_bit(fast_req);
    end

    assign rk.req = norm_req;
    assign rk.lvl = prio_r;                // R7

    // Normal request passes only above the mask
    assign nsig = rk.valid && (rk.win_lvl > mask_r); // R8 R9

    // =====================================================
    // Access qualification
    always_comb begin
        wr_ok    = i_wr && i_supervisor;   // R4
        rd_ok    = i_rd && i_supervisor;   // R4
        priv_bad = (i_wr || i_rd) && !i_supervisor;
        prio_hit = (i_addr & pic_pkg::PRIO_MASK) == pic_pkg::A_PRIO;
    end

    // =====================================================
    // Register writes
    always_comb begin
        enable_nxt = enable_r;
        type_nxt   = type_r;
        mask_nxt   = mask_r;
        prio_nxt   = prio_r;
        ien_nxt    = ien_r;
        clr        = '0;
        if (wr_ok) begin
            unique case (i_addr)
                pic_pkg::A_ENABLE0: begin
                    enable_nxt[0 +: DW] = i_wdata;  // R2
                end
                pic_pkg::A_ENABLE1: begin
                    enable_nxt[DW +: DW] = i_wdata; // R2
                end
                pic_pkg::A_EN_NUM: begin
                    enable_nxt[i_wdata[pic_pkg::SRC_W-1:0]] = 1'b1; // R2
                end
                pic_pkg::A_DIS_NUM: begin
                    enable_nxt[i_wdata[pic_pkg::SRC_W-1:0]] = 1'b0; // R2
                end
                pic_pkg::A_TYPE0: begin
                    type_nxt[0 +: DW] = i_wdata;
                end
                pic_pkg::A_TYPE1: begin
                    type_nxt[DW +: DW] = i_wdata;
                end
                pic_pkg::A_MASK: begin
                    mask_nxt = i_wdata[pic_pkg::LVL_W-1:0]; // R8
                end
                pic_pkg::A_ICLR: begin
                    clr = i_wdata[pic_pkg::NEV-1:0];
                end
                pic_pkg::A_IEN: begin
                    ien_nxt = i_wdata[pic_pkg::NEV-1:0];
                end
                default: begin
                    if (prio_hit) begin
                        prio_nxt[i_addr[pic_pkg::PRIO_IDX_W-1:0] * DW +: DW] = i_wdata; // R7
                    end
                end
            endcase
        end
    end

    // =====================================================
    // Register reads, data in the following cycle only
    always_comb begin
        rdata_nxt = '0;
        if (rd_ok) begin
            unique case (i_addr)
                pic_pkg::A_ENABLE0: rdata_nxt = enable_r[0 +: DW];
                pic_pkg::A_ENABLE1: rdata_nxt = enable_r[DW +: DW];
                pic_pkg::A_TYPE0:   rdata_nxt = type_r[0 +: DW];
                pic_pkg::A_TYPE1:   rdata_nxt = type_r[DW +: DW];
                pic_pkg::A_MASK:    rdata_nxt = DW'(mask_r);
                pic_pkg::A_VECTOR:  rdata_nxt = DW'(vec_r);
                pic_pkg::A_RAW0:    rdata_nxt = s2_r[0 +: DW];
                pic_pkg::A_RAW1:    rdata_nxt = s2_r[DW +: DW];
                pic_pkg::A_ISTAT:   rdata_nxt = DW'(istat_r);
                pic_pkg::A_IEN:     rdata_nxt = DW'(ien_r);
                default: begin
                    if (prio_hit) begin
                        rdata_nxt = prio_r[i_addr[pic_pkg::PRIO_IDX_W-1:0] * DW +: DW];
                    end
                end
            endcase
        end
    end

    // =====================================================
    // Requests, vector and event status
    always_comb begin
        firq_nxt = fast_any;               // R3 R10
        nirq_nxt = nsig;                   // R9 R10
        vec_nxt  = '0;
        if (fast_any) begin
            vec_nxt[pic_pkg::SRC_W-1:0] = fast_idx; // R5
            vec_nxt[pic_pkg::VEC_VALID] = 1'b1;
            vec_nxt[pic_pkg::VEC_FAST]  = 1'b1;
        end else if (nsig) begin
            vec_nxt[pic_pkg::SRC_W-1:0] = rk.idx;   // R5
            vec_nxt[pic_pkg::VEC_VALID] = 1'b1;
            vec_nxt[pic_pkg::VEC_LVL +: pic_pkg::LVL_W] = rk.win_lvl;
        end
        ev = '0;
        ev[pic_pkg::EV_PRIV] = priv_bad;
        ev[pic_pkg::EV_NREQ] = nsig && !nirq_r;
        ev[pic_pkg::EV_FREQ] = fast_any && !firq_r;
        // Set wins over a clear in the same cycle
        istat_nxt = (istat_r & ~clr) | ev;
        irq_nxt   = |(istat_nxt & ien_nxt);
    end

    // Register stage
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            enable_r <= '0;
            type_r   <= '0;
            mask_r   <= pic_pkg::MASK_RST;
            prio_r   <= '0;
            istat_r  <= '0;
            ien_r    <= '0;
            rdata_r  <= '0;
            nirq_r   <= 1'b0;
            firq_r   <= 1'b0;
            vec_r    <= '0;
            irq_r    <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            type_r   <= type_nxt;
            mask_r   <= mask_nxt;
            prio_r   <= prio_nxt;
            istat_r  <= istat_nxt;
            ien_r    <= ien_nxt;
            rdata_r  <= rdata_nxt;
            nirq_r   <= nirq_nxt;
            firq_r   <= firq_nxt;
            vec_r    <= vec_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign o_rdata  = rdata_r;
    assign o_nirq   = nirq_r;
    assign o_firq   = firq_r;
    assign o_vector = vec_r;
    assign o_irq    = irq_r;

    // =====================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // Unprivileged write leaves setup untouched
    property p_priv_wr;
        (i_wr && !i_supervisor) |=> (enable_r == $past(enable_r)) && (prio_r == $past(prio_r))
            && (mask_r == $past(mask_r)) && (type_r == $past(type_r));
    endproperty
    a_priv_wr: assert property (p_priv_wr) else $error("unprivileged write changed state"); // R4

    // Unprivileged read returns zero and flags an event
    property p_priv_rd;
        (i_rd && !i_supervisor) |=> (o_rdata == '0) && istat_r[pic_pkg::EV_PRIV];
    endproperty
    a_priv_rd: assert property (p_priv_rd) else $error("unprivileged read not refused"); // R4

    // Enable by number sets the numbered bit
    property p_en_num;
        logic [pic_pkg::SRC_W-1:0] n;
        (wr_ok && i_addr == pic_pkg::A_EN_NUM, n = i_wdata[pic_pkg::SRC_W-1:0]) |=> enable_r[n];
    endproperty
    a_en_num: assert property (p_en_num) else $error("enable by number failed"); // R2

    // Disable by number clears the numbered bit
    property p_dis_num;
        logic [pic_pkg::SRC_W-1:0] n;
        (wr_ok && i_addr == pic_pkg::A_DIS_NUM, n = i_wdata[pic_pkg::SRC_W-1:0]) |=> !enable_r[n];
    endproperty
    a_dis_num: assert property (p_dis_num) else $error("disable by number failed"); // R2

    // Fast request follows a steady enabled fast source after sync and register
    property p_fast_lat;
        ($stable(enable_r & type_r) && (i_src & enable_r & type_r) != '0) [*3] |=> o_firq;
    endproperty
    a_fast_lat: assert property (p_fast_lat) else $error("fast request missing"); // R3

    // Normal request only above the mask
    property p_mask;
        o_nirq |-> $past(rk.valid) && ($past(rk.win_lvl) > $past(mask_r));
    endproperty
    a_mask: assert property (p_mask) else $error("normal request at or below mask"); // R9

    // Winner really is requested and holds its stored level
    property p_winner;
        rk.valid |-> norm_req[rk.idx] && (pic_pkg::lvl_of(prio_r, rk.idx) == rk.win_lvl);
    endproperty
    a_winner: assert property (p_winner) else $error("ranking winner inconsistent"); // R5 R6

    // Fast source wins the vector over normal ones
    property p_fast_first;
        (fast_any && nsig) |=> o_vector[pic_pkg::VEC_FAST] && o_vector[pic_pkg::VEC_VALID];
    endproperty
    a_fast_first: assert property (p_fast_first) else $error("normal ranked ahead of fast"); // R5

    // Request drops once no enabled source remains
    property p_level;
        (pend == '0) |=> !o_firq && !o_nirq;
    endproperty
    a_level: assert property (p_level) else $error("request held without source"); // R10

    // Event set beats a clear in the same cycle
    property p_set_wins;
        ((ev & clr) != '0) |=> ((istat_r & $past(ev & clr)) == $past(ev & clr));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    // Read data stands only in the cycle after a read
    property p_rd_idle;
        !i_rd |=> (o_rdata == '0);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

    // Fast request always shows a fast, valid vector
    property p_firq_vec;
        o_firq |-> o_vector[pic_pkg::VEC_FAST] && o_vector[pic_pkg::VEC_VALID];
    endproperty
    a_firq_vec: assert property (p_firq_vec) else $error("fast request without fast vector"); // R5

    // Normal vector level lies above the mask it passed
    property p_nvec_lvl;
        (o_nirq && !o_firq) |-> (o_vector[pic_pkg::VEC_LVL +: pic_pkg::LVL_W] > $past(mask_r));
    endproperty
    a_nvec_lvl: assert property (p_nvec_lvl) else $error("normal vector level at or below mask"); // R9

    // Event interrupt only with an enabled status bit
    property p_irq_src;
        o_irq |-> ((istat_r & ien_r) != '0);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("event interrupt without enabled status");

    // Scenarios
    c_fast:  cover property (o_firq);
    c_norm:  cover property (o_nirq && !o_firq);
    c_both:  cover property (o_firq && o_nirq);
    c_priv:  cover property (i_wr && !i_supervisor);
    c_irq:   cover property (o_irq);
endmodule

// file: inc/pic_pkg.sv
// =====================================================
// Shared constants for the interrupt controller
package pic_pkg;

    // Sizes
    localparam int NSRC    = 128;
    localparam int SRC_W   = 7;
    localparam int LVL_W   = 4;
    localparam int DATA_W  = 64;
    localparam int ADDR_W  = 6;
    localparam int NPRIO   = 8;
    localparam int PRIO_IDX_W = 3;
    localparam int NEV     = 3;
    localparam int VEC_W   = 13;

    // Register word addresses
    localparam logic [ADDR_W-1:0] A_ENABLE0 = 6'h00;
    localparam logic [ADDR_W-1:0] A_ENABLE1 = 6'h01;
    localparam logic [ADDR_W-1:0] A_EN_NUM  = 6'h02;
    localparam logic [ADDR_W-1:0] A_DIS_NUM = 6'h03;
    localparam logic [ADDR_W-1:0] A_TYPE0   = 6'h04;
    localparam logic [ADDR_W-1:0] A_TYPE1   = 6'h05;
    localparam logic [ADDR_W-1:0] A_MASK    = 6'h06;
    localparam logic [ADDR_W-1:0] A_VECTOR  = 6'h07;
    localparam logic [ADDR_W-1:0] A_PRIO    = 6'h08;
    localparam logic [ADDR_W-1:0] PRIO_MASK = 6'h38;
    localparam logic [ADDR_W-1:0] A_RAW0    = 6'h10;
    localparam logic [ADDR_W-1:0] A_RAW1    = 6'h11;
    localparam logic [ADDR_W-1:0] A_ISTAT   = 6'h12;
    localparam logic [ADDR_W-1:0] A_ICLR    = 6'h13;
    localparam logic [ADDR_W-1:0] A_IEN     = 6'h14;

    // Event bits of the status register
    localparam int EV_PRIV = 0;
    localparam int EV_NREQ = 1;
    localparam int EV_FREQ = 2;

    // Vector register fields
    localparam int VEC_VALID = 7;
    localparam int VEC_FAST  = 8;
    localparam int VEC_LVL   = 9;

    // Reset values
    localparam logic [LVL_W-1:0] MASK_RST = 4'h0;

    // Level field of one source in the packed level store
    function automatic logic [LVL_W-1:0] lvl_of(logic [NSRC*LVL_W-1:0] p, logic [SRC_W-1:0] i);
        lvl_of = p[{i, 2'b00} +: LVL_W];
    endfunction

endpackage

// file: inc/pic_prio_if.sv
`timescale 1ns/1ps
// =====================================================
// Ranking request and answer between control and ranker
interface pic_prio_if;
    logic [pic_pkg::NSRC-1:0]           req;
    logic [pic_pkg::NSRC*pic_pkg::LVL_W-1:0] lvl;
    logic                               valid;
    logic [pic_pkg::SRC_W-1:0]          idx;
    logic [pic_pkg::LVL_W-1:0]          win_lvl;

    modport requester (output req, lvl, input valid, idx, win_lvl);
    modport ranker    (input req, lvl, output valid, idx, win_lvl);
endinterface

// file: verilog/prio_rank.sv
`timescale 1ns/1ps
// =====================================================
// Normal request ranking: highest level, then highest number
module prio_rank (
    pic_prio_if.ranker p
);
    logic                      v;
    logic [pic_pkg::SRC_W-1:0] ix;
    logic [pic_pkg::LVL_W-1:0] lv;

    // Ascending scan; ties go to the later, higher source
    always_comb begin
        v  = 1'b0;
        ix = '0;
        lv = '0;
        for (int i = 0; i < pic_pkg::NSRC; i++) begin
            if (p.req[i] && (!v || pic_pkg::lvl_of(p.lvl, 7'(i)) >= lv)) begin // R5 R6
                v  = 1'b1;
                ix = 7'(i);
                lv = pic_pkg::lvl_of(p.lvl, 7'(i));
            end
        end
    end

    assign p.valid   = v;
    assign p.idx     = ix;
    assign p.win_lvl = lv;
endmodule

// file: test/core_model.sv
`timescale 1ns/1ps
// ==========================================
// Core side: takes a request on its rise
module core_model (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_sys_rst,
    // Requests from the controller
    input  wire logic                      i_nirq,
    input  wire logic                      i_firq,
    input  wire logic [pic_pkg::VEC_W-1:0] i_vector,
    // What the core took
    output logic      [pic_pkg::VEC_W-1:0] o_taken_vec,
    output logic      [7:0]                o_take_cnt
);
    logic req_q;

    // Latch the vector when a new request appears
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            req_q       <= 1'b0;
            o_taken_vec <= 13'h0000;
            o_take_cnt  <= 8'h00;
        end else begin
            req_q <= i_nirq | i_firq;
            if ((i_nirq | i_firq) && !req_q) begin
                o_taken_vec <= i_vector;
                o_take_cnt  <= o_take_cnt + 8'h01;
            end
        end
    end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
// ==========================================
// Self-checking bench for the controller
module tb;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    logic [127:0]                src = '0;
    logic [5:0]                  addr = 6'h00;
    logic [63:0]                 wdata = 64'h0;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic                        sup = 1'b0;
    logic [63:0]                 rdata;
    logic                        nirq;
    logic                        firq;
    logic                        irq;
    logic [12:0]                 vec;
    logic [12:0]                 taken;
    logic [7:0]                  takes;
    logic [63:0]                 d;
    int                          err_total = 0;
    int                          samples_checked = 0;

    // Clock at 250 MHz
    always #2 clk = ~clk;

    pic_top u_pic_top (.i_core_clk(clk), .i_sys_rst(rst), .i_src(src), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_supervisor(sup), .o_rdata(rdata), .o_nirq(nirq), .o_firq(firq),
        .o_vector(vec), .o_irq(irq));
    core_model u_core_model (.i_core_clk(clk), .i_sys_rst(rst), .i_nirq(nirq), .i_firq(firq),
        .i_vector(vec), .o_taken_vec(taken), .o_take_cnt(takes));

    // Expected vector word
    function automatic logic [12:0] ev(int s, bit f, int l);
        return {l[3:0], f, 1'b1, s[6:0]};
    endfunction

    // One-cycle bus write, privileged unless told otherwise
    task automatic bw(logic [5:0] a, logic [63:0] v, logic s = 1'b1);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v; sup <= s;
        @(posedge clk);
        wr <= 1'b0; sup <= 1'b0;
    endtask

    // One-cycle bus read, data taken the cycle after
    task automatic br(logic [5:0] a, output logic [63:0] v, input logic s = 1'b1);
        @(posedge clk);
        rd <= 1'b1; addr <= a; sup <= s;
        @(posedge clk);
        rd <= 1'b0; sup <= 1'b0;
        #1 v = rdata;
    endtask

    // Let a source or setting reach the request outputs
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Reset values
    task automatic t_reset();
        br(pic_pkg::A_MASK, d);
        `CHK("mask", 64'h0, d)
        br(pic_pkg::A_ENABLE0, d);
        `CHK("enable0", 64'h0, d)
        `CHK("requests", 3'b000, {nirq, firq, irq})
        $display("test reset done");
    endtask

    // Enables by number and word, fast type
    task automatic t_fast();
        bw(pic_pkg::A_EN_NUM, 64'd9);
        bw(pic_pkg::A_TYPE0, 64'h200);
        @(posedge clk) src[9] <= 1'b1;
        settle();
        `CHK("firq", 2'b01, {nirq, firq})
        `CHK("vector", ev(9, 1, 0), vec)
        `CHK("core took", ev(9, 1, 0), taken)
        br(pic_pkg::A_VECTOR, d);
        `CHK("vector reg", ev(9, 1, 0), d)
        br(pic_pkg::A_RAW0, d);
        `CHK("raw0", 64'h200, d)
        bw(pic_pkg::A_ENABLE1, 64'h8000_0000_0000_0000);
        bw(pic_pkg::A_TYPE1, 64'h8000_0000_0000_0000);
        @(posedge clk) src[127] <= 1'b1;
        settle();
        `CHK("vector top", ev(127, 1, 0), vec)
        br(pic_pkg::A_ENABLE0, d);
        `CHK("enable0", 64'h200, d)
        bw(pic_pkg::A_DIS_NUM, 64'd9);
        bw(pic_pkg::A_DIS_NUM, 64'd127);
        settle();
        `CHK("firq off", 1'b0, firq)
        @(posedge clk) src <= '0;
        bw(pic_pkg::A_TYPE0, 64'h0);
        bw(pic_pkg::A_TYPE1, 64'h0);
        $display("test fast done");
    endtask

    // Level ranking among normal sources
    task automatic t_rank();
        bw(pic_pkg::A_PRIO, 64'h0030_0000);
        bw(pic_pkg::A_PRIO + 6'h01, 64'h0003_0000);
        bw(pic_pkg::A_PRIO + 6'h04, 64'h0700_0000);
        bw(pic_pkg::A_ENABLE0, 64'h0010_0020);
        bw(pic_pkg::A_ENABLE1, 64'h40);
        @(posedge clk) begin
            src[5] <= 1'b1; src[20] <= 1'b1; src[70] <= 1'b1;
        end
        settle();
        `CHK("nirq", 1'b1, nirq)
        `CHK("vector 70", ev(70, 0, 7), vec)
        br(pic_pkg::A_PRIO + 6'h04, d);
        `CHK("level reg", 64'h0700_0000, d)
        @(posedge clk) src[70] <= 1'b0;
        settle();
        `CHK("vector 20", ev(20, 0, 3), vec)
        bw(pic_pkg::A_EN_NUM, 64'd9);
        bw(pic_pkg::A_TYPE0, 64'h200);
        @(posedge clk) src[9] <= 1'b1;
        settle();
        `CHK("fast first", ev(9, 1, 0), vec)
        @(posedge clk) src[9] <= 1'b0;
        bw(pic_pkg::A_TYPE0, 64'h0);
        $display("test rank done");
    endtask

    // Mask threshold and level zero
    task automatic t_mask();
        bw(pic_pkg::A_MASK, 64'h3);
        settle();
        `CHK("nirq at mask", 1'b0, nirq)
        br(pic_pkg::A_MASK, d);
        `CHK("mask", 64'h3, d)
        @(posedge clk);
        #1;
        `CHK("rdata once", 64'h0, rdata)
        bw(pic_pkg::A_MASK, 64'h2);
        settle();
        `CHK("nirq below", 1'b1, nirq)
        bw(pic_pkg::A_MASK, 64'h0);
        bw(pic_pkg::A_EN_NUM, 64'd33);
        @(posedge clk) src <= 128'h2_0000_0000;
        settle();
        `CHK("level zero", 1'b0, nirq)
        @(posedge clk) src <= '0;
        bw(pic_pkg::A_ENABLE0, 64'h0);
        bw(pic_pkg::A_ENABLE1, 64'h0);
        $display("test mask done");
    endtask

    // Unprivileged access and event interrupt
    task automatic t_priv();
        bw(pic_pkg::A_ICLR, 64'h7);
        bw(pic_pkg::A_IEN, 64'h1);
        br(pic_pkg::A_IEN, d);
        `CHK("event enable", 64'h1, d)
        bw(pic_pkg::A_MASK, 64'h5, 1'b0);
        br(pic_pkg::A_MASK, d);
        `CHK("mask kept", 64'h0, d)
        br(pic_pkg::A_ISTAT, d);
        `CHK("status", 64'h1, d)
        `CHK("irq", 1'b1, irq)
        bw(pic_pkg::A_ICLR, 64'h1);
        #1;
        `CHK("irq clr", 1'b0, irq)
        br(pic_pkg::A_MASK, d, 1'b0);
        `CHK("priv read", 64'h0, d)
        bw(pic_pkg::A_IEN, 64'h2);
        #1;
        `CHK("irq masked", 1'b0, irq)
        br(6'h3F, d);
        `CHK("unmapped", 64'h0, d)
        bw(pic_pkg::A_PRIO + 6'h02, 64'h1_0000_0000);
        bw(pic_pkg::A_EN_NUM, 64'd40);
        @(posedge clk) src[40] <= 1'b1;
        @(posedge clk);
        // Clear lands in the cycle the normal event is raised
        bw(pic_pkg::A_ICLR, 64'h2);
        settle();
        `CHK("nirq event", 2'b11, {nirq, irq})
        `CHK("core took", ev(40, 0, 1), taken)
        br(pic_pkg::A_ISTAT, d);
        `CHK("set beats clear", 64'h3, d)
        `CHK("core takes", 8'h04, takes)
        $display("test priv done");
    endtask

    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fast();
        t_rank();
        t_mask();
        t_priv();
        close_out();
    end
endmodule
